// ===== verilog/adcsp_defs.vh
// constants for the converter serial host port
`ifndef ADCSP_DEFS_VH
`define ADCSP_DEFS_VH

// ============================================================
// word and buffer geometry
`define ADCSP_WORD_BITS 24
`define ADCSP_CNT_BITS 5
`define ADCSP_FIFO_DEPTH 16
`define ADCSP_FIFO_AW 4

// ============================================================
// reset values of the host-visible registers
`define ADCSP_CTRL_RESET 24'h000000
`define ADCSP_CAL_RESET 24'h000000

// ============================================================
// timing: master clock and self-clocking pulse widths
`define ADCSP_CLK_MHZ 20
`define ADCSP_SCK_HI_NS 50
`define ADCSP_SCK_LO_NS 150
// highest allowed external serial clock is master clock over this
`define ADCSP_EXT_RATIO 5
`define ADCSP_SCK_HI_CYC ((`ADCSP_SCK_HI_NS * `ADCSP_CLK_MHZ + 999) / 1000)
`define ADCSP_SCK_LO_CYC ((`ADCSP_SCK_LO_NS * `ADCSP_CLK_MHZ + 999) / 1000)

`endif

// ===== verilog/adcsp_fifo.v
// result buffer between converter and serial port
`timescale 1ns/100ps
module adcsp_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire reset,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	// ============================================================
	// storage and pointers
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // word store
	reg [AW-1:0] wr_ptr_q; // next slot to fill
	reg [AW-1:0] rd_ptr_q; // oldest word
	reg [AW:0] count_q; // words held
	reg ready_q; // registered not-full
	reg valid_q; // registered not-empty
	wire push; // accepted write
	wire pop; // accepted read
	reg [AW:0] count_d;

	assign push = in_valid & ready_q;
	assign pop = valid_q & out_ready;
	assign in_ready = ready_q;
	assign out_valid = valid_q;
	assign out_data = mem[rd_ptr_q];

	// next fill level
	always @*
	begin
		count_d = count_q;
		if (push & ~pop)
			count_d = count_q + 1'b1;
		else if (pop & ~push)
			count_d = count_q - 1'b1;
	end

	// memory write has no reset, contents are don't-care until pushed
	always @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	// pointers and flags; flags registered so the port sees clean levels
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_q <= 4'h0;
			rd_ptr_q <= 4'h0;
			count_q <= 5'h00;
			ready_q <= 1'b1;
			valid_q <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			count_q <= count_d;
			ready_q <= (count_d != DEPTH[AW:0]);
			valid_q <= (count_d != {(AW+1){1'b0}});
		end
	end
endmodule // adcsp_fifo

// ===== verilog/adcsp_port.v
// serial host port of the converter: strobes, clock modes, register access
`timescale 1ns/100ps
`include "adcsp_defs.vh"
module adcsp_port (
	input wire clk,
	input wire reset,
	// host pins
	input wire mode_sel,
	input wire read_strobe_n,
	input wire write_strobe_n,
	input wire register_select,
	input wire sclk_in,
	output wire sclk_out,
	output wire sclk_oe,
	input wire sdata_in,
	output wire sdata_out,
	output wire sdata_oe,
	output wire result_ready_n,
	// converter side
	input wire [23:0] result_data,
	input wire result_valid,
	output wire result_ready,
	output wire [23:0] ctrl_word,
	output wire [23:0] cal_word
);
	// ============================================================
	// states of the transfer engine
	localparam ST_IDLE = 2'b00; // waiting for a strobe
	localparam ST_SHIFT = 2'b01; // bits moving
	localparam ST_DONE = 2'b10; // word complete, waiting for strobe to rise

	// target codes for a transfer
	localparam TG_CTRL = 2'b00;
	localparam TG_DATA = 2'b01;
	localparam TG_CAL = 2'b10;

	// integer forms first, then cut to the counter widths on purpose
	localparam integer WORD_LAST_I = `ADCSP_WORD_BITS - 1;
	localparam integer HI_CYC_I = `ADCSP_SCK_HI_CYC;
	localparam integer LO_CYC_I = `ADCSP_SCK_LO_CYC;
	localparam [4:0] WORD_LAST = WORD_LAST_I[4:0]; // index of the last bit
	localparam [1:0] HI_CYC = HI_CYC_I[1:0]; // self clock high width
	localparam [1:0] LO_CYC = LO_CYC_I[1:0]; // self clock low width

	// target chosen by select line and direction; select low is control
	function [1:0] pick_target;
		input sel;
		input is_read;
		begin
			if (!sel)
				pick_target = TG_CTRL;
			else if (is_read)
				pick_target = TG_DATA;
			else
				pick_target = TG_CAL;
		end
	endfunction

	// ============================================================
	// input synchronisers: every pin crosses two flops first
	localparam NSYNC = 6;
	wire [NSYNC-1:0] pin_raw;
	wire [NSYNC-1:0] pin_s; // second stage, the only one logic reads
	assign pin_raw = {mode_sel, read_strobe_n, write_strobe_n, register_select, sclk_in,
		sdata_in};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1)
		begin : g_sync
			reg s1_q;
			reg s2_q;
			// idle-high reset keeps strobes inactive and clock at rest
			always @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					s1_q <= 1'b1;
					s2_q <= 1'b1;
				end
				else
				begin
					s1_q <= pin_raw[gi];
					s2_q <= s1_q;
				end
			end
			assign pin_s[gi] = s2_q;
		end
	endgenerate

	wire mode_s = pin_s[5];
	wire rd_n_s = pin_s[4];
	wire wr_n_s = pin_s[3];
	wire sel_s = pin_s[2];
	wire sck_s = pin_s[1];
	wire din_s = pin_s[0];

	// ============================================================
	// registers
	reg [1:0] state_q; // transfer engine state
	reg self_q; // mode latched between transfers
	reg is_read_q; // current transfer direction
	reg [1:0] target_q; // current register target
	reg [23:0] shift_q; // serial shift register
	reg [4:0] bit_q; // bits sampled so far, survives clock pauses
	reg sck_prev_q; // last synced external clock level
	reg sck_gen_q; // self-generated clock level
	reg sck_oe_q; // we drive the clock line
	reg [1:0] div_q; // pulse-width divider
	reg sdo_q; // data line output
	reg sdo_oe_q; // we drive the data line
	reg rdy_n_q; // fresh result waiting
	reg [23:0] ctrl_q; // control register
	reg [23:0] cal_q; // calibration register
	reg [23:0] data_q; // last conversion handed to the host

	// converter results buffer
	wire [23:0] fifo_data;
	wire fifo_valid;
	reg fifo_pop;

	adcsp_fifo #(
		.WIDTH(`ADCSP_WORD_BITS),
		.DEPTH(`ADCSP_FIFO_DEPTH),
		.AW(`ADCSP_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_data(result_data),
		.in_valid(result_valid),
		.in_ready(result_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// ============================================================
	// serial clock events, unified across the two modes
	wire strobe_lo = ~rd_n_s | ~wr_n_s;
	// the strobe of the running transfer; the other one is ignored mid-word
	wire act_strobe_hi = is_read_q ? rd_n_s : wr_n_s;
	wire div_end = (div_q == 2'b00);
	// self mode: edges are our own toggles
	wire self_rise = self_q & sck_oe_q & ~sck_gen_q & div_end;
	wire self_fall = self_q & sck_oe_q & sck_gen_q & div_end;
	// external mode: edges found by the sampled pin; host keeps it under master/5
	wire ext_rise = ~self_q & sck_s & ~sck_prev_q;
	wire ext_fall = ~self_q & ~sck_s & sck_prev_q;
	wire sck_rise = self_rise | ext_rise;
	wire sck_fall = self_fall | ext_fall;
	wire word_end = sck_rise & (bit_q == WORD_LAST);

	// ============================================================
	// transfer engine
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= ST_IDLE;
			self_q <= 1'b0;
			is_read_q <= 1'b0;
			target_q <= TG_CTRL;
			shift_q <= 24'h000000;
			bit_q <= 5'h00;
			sck_prev_q <= 1'b1;
			sck_gen_q <= 1'b1;
			sck_oe_q <= 1'b0;
			div_q <= 2'h0;
			sdo_q <= 1'b0;
			sdo_oe_q <= 1'b0;
			ctrl_q <= `ADCSP_CTRL_RESET;
			cal_q <= `ADCSP_CAL_RESET;
			data_q <= 24'h000000;
		end
		else
		begin
			sck_prev_q <= sck_s;
			case (state_q)
				ST_IDLE:
				begin
					// mode strap is taken only between transfers
					self_q <= mode_s;
					sck_gen_q <= 1'b1;
					bit_q <= 5'h00;
					if (strobe_lo)
					begin
						// read wins if both strobes fall together
						is_read_q <= ~rd_n_s;
						target_q <= pick_target(sel_s, ~rd_n_s);
						state_q <= ST_SHIFT;
						div_q <= LO_CYC;
						// self mode: start driving the clock; external: never drive it
						sck_oe_q <= mode_s;
						if (!rd_n_s)
						begin
							// load the chosen word and present its first bit
							if (!sel_s)
							begin
								shift_q <= ctrl_q;
								sdo_q <= ctrl_q[23];
							end
							else
							begin
								shift_q <= fifo_valid ? fifo_data : data_q;
								sdo_q <= fifo_valid ? fifo_data[23] : data_q[23];
								if (fifo_valid)
									data_q <= fifo_data;
							end
							sdo_oe_q <= 1'b1;
						end
					end
				end
				ST_SHIFT:
				begin
					if (act_strobe_hi)
					begin
						// strobe returned early: release both lines at once
						sck_oe_q <= 1'b0;
						sdo_oe_q <= 1'b0;
						sck_gen_q <= 1'b1;
						state_q <= ST_IDLE;
					end
					else
					begin
						// self clock: high and low widths from the divider
						if (self_q)
						begin
							if (div_end)
							begin
								sck_gen_q <= ~sck_gen_q;
								div_q <= sck_gen_q ? LO_CYC : HI_CYC;
							end
							else
								div_q <= div_q - 2'b01;
						end
						// bit position only moves on edges, so pauses keep it
						if (sck_rise)
						begin
							bit_q <= bit_q + 5'h01;
							if (!is_read_q)
								shift_q <= {shift_q[22:0], din_s};
						end
						// the first fall only opens the frame: the msb is already out
						// and the host takes it on the first rise, so no shift there
						if (sck_fall & is_read_q & (bit_q != 5'h00))
						begin
							shift_q <= {shift_q[22:0], 1'b0};
							sdo_q <= shift_q[22];
						end
						if (word_end)
						begin
							// whole word moved: stop the clock even with strobe low
							state_q <= ST_DONE;
							sck_oe_q <= 1'b0;
							sck_gen_q <= 1'b1;
							if (!is_read_q)
							begin
								if (target_q == TG_CTRL)
									ctrl_q <= {shift_q[22:0], din_s};
								else
									cal_q <= {shift_q[22:0], din_s};
							end
						end
					end
				end
				ST_DONE:
				begin
					// hold the last bit until the host lets the strobe rise
					sck_oe_q <= 1'b0;
					if (act_strobe_hi)
					begin
						sdo_oe_q <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
					sck_oe_q <= 1'b0;
					sdo_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// ============================================================
	// buffer pop: one word leaves when a data read starts
	always @*
	begin
		fifo_pop = (state_q == ST_IDLE) & ~rd_n_s & sel_s & fifo_valid;
	end

	// ready flag: low while a result is waiting; the cycle after a data read pops
	// a word it goes high, then follows the buffer level again
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			rdy_n_q <= 1'b1;
		else if (fifo_pop)
			rdy_n_q <= 1'b1;
		else
			rdy_n_q <= ~fifo_valid;
	end

	// ============================================================
	// outputs, each straight from a flop
	assign sclk_out = sck_gen_q;
	assign sclk_oe = sck_oe_q;
	assign sdata_out = sdo_q;
	assign sdata_oe = sdo_oe_q;
	assign result_ready_n = rdy_n_q;
	assign ctrl_word = ctrl_q;
	assign cal_word = cal_q;
endmodule // adcsp_port

// ===== tb/adcsp_port_props.sv
// pin-level checks of the serial host port
`timescale 1ns/100ps
module adcsp_port_props (
	input wire clk,
	input wire reset,
	input wire mode_sel,
	input wire read_strobe_n,
	input wire write_strobe_n,
	input wire sclk_out,
	input wire sclk_oe,
	input wire sdata_oe,
	input wire result_ready_n,
	input wire result_ready,
	input wire [23:0] ctrl_word,
	input wire [23:0] cal_word
);
	reg [4:0] rise_q; // self clock rises seen in this frame
	// ========
	// the last rise drops the enable, so 23 is the top count
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			rise_q <= 5'h00;
		else if (!sclk_oe)
			rise_q <= 5'h00;
		else if ($rose(sclk_out))
			rise_q <= rise_q + 5'h01;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence idle_s;
		read_strobe_n && write_strobe_n;
	endsequence
	// a strobe falls while the port is idle in self mode
	sequence start_s;
		(($fell(read_strobe_n) && write_strobe_n) || ($fell(write_strobe_n) && read_strobe_n))
		&& mode_sel && !sclk_oe && !sdata_oe;
	endsequence
	chk_self_mode: assert property ($rose(sclk_oe) |-> mode_sel)
		else $error("clock driven outside self mode");
	chk_clock_start: assert property (start_s |-> ##[1:6] sclk_oe)
		else $error("self clock not started");
	chk_clock_toggle: assert property (
		$rose(sclk_out) && sclk_oe |-> ##[1:5] (!sclk_out || !sclk_oe))
		else $error("self clock stuck high");
	chk_clock_release: assert property (idle_s [*5] |-> !sclk_oe)
		else $error("clock driven after strobe rise");
	chk_data_release: assert property (idle_s [*5] |-> !sdata_oe)
		else $error("data driven after strobe rise");
	chk_word_end: assert property (
		sclk_oe && $rose(sclk_out) |-> rise_q < 5'h17)
		else $error("self clock ran past one word");
	chk_full_flag: assert property (!result_ready |-> !result_ready_n)
		else $error("full buffer not flagged");
	chk_pop_read: assert property ($rose(result_ready_n) |-> sdata_oe)
		else $error("buffer drained without a read");
	chk_store_write: assert property (
		!$stable({ctrl_word, cal_word}) |-> !write_strobe_n)
		else $error("register changed outside a write");
endmodule // adcsp_port_props
bind adcsp_port adcsp_port_props u_adcsp_port_props (.clk(clk), .reset(reset),
	.mode_sel(mode_sel), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
	.sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdata_oe(sdata_oe),
	.result_ready_n(result_ready_n), .result_ready(result_ready),
	.ctrl_word(ctrl_word), .cal_word(cal_word));

// ===== tb/adcsp_host.sv
// host controller model driving the serial port pins
`timescale 1ns/100ps
module adcsp_host (
	input wire clk,
	input wire sck_w,
	input wire sclk_oe,
	input wire sdo,
	output reg mode_sel,
	output reg rd_n,
	output reg wr_n,
	output reg sel,
	output reg sck,
	output reg sdi
);
	integer hang = 0; // waits that ran out
	reg oe_end; // clock enable just before strobe rise
	// ========
	// idle: strobes high, clock parked high
	initial
	begin
		mode_sel = 0;
		rd_n = 1;
		wr_n = 1;
		sel = 0;
		sck = 1;
		sdi = 0;
	end
	// bounded wait for a level on the clock wire
	task wt(input v);
		integer k;
		begin
			for (k = 0; k < 60 && sck_w !== v; k = k + 1)
				@(posedge clk);
			if (k == 60)
				hang = hang + 1;
		end
	endtask
	// one frame of n bits; data set on fall, sampled on rise
	task xfer(input rd, input md, input s, input [23:0] w, input integer n,
		input gap, output [23:0] r);
		integer i;
		begin
			@(posedge clk);
			mode_sel <= md;
			sel <= s;
			repeat (4) @(posedge clk);
			if (rd)
				rd_n <= 0;
			else
				wr_n <= 0;
			for (i = 0; i < n; i = i + 1)
			begin
				if (md)
					wt(0);
				else
					sck <= 0;
				sdi <= w[23 - i];
				if (md)
					wt(1);
				else
					repeat (4) @(posedge clk);
				sck <= 1;
				r = {r[22:0], sdo};
				// 8 clk period keeps within master/5; gap pauses mid-word
				if (!md)
					repeat (4 + ((gap && i % 8 == 3) ? 12 : 0)) @(posedge clk);
			end
			repeat (6) @(posedge clk);
			oe_end = sclk_oe;
			rd_n <= 1;
			wr_n <= 1;
			sdi <= ~sdi; // released line must not keep the last bit
			repeat (6) @(posedge clk);
		end
	endtask
endmodule // adcsp_host

// ===== tb/adc_serial_port_clock_select_bench.sv
// bench for the serial host port: clock modes, registers, buffer
`timescale 1ns/100ps
module adc_serial_port_clock_select_bench;
	reg clk = 0;
	reg reset = 1;
	reg res_v = 0;
	reg [23:0] res_d = 24'h000000;
	reg [23:0] r;
	reg [4:0] k;
	wire mode_sel, rd_n, wr_n, sel, h_sck, sdi;
	wire sclk_out, sclk_oe, sdata_out, sdata_oe, rrdy_n, res_rdy;
	wire [23:0] ctrl_word, cal_word;
	wire sck_w = sclk_oe ? sclk_out : h_sck; // level on the shared clock wire
	wire sd_w = sdata_oe ? sdata_out : sdi; // level on the shared data wire
	integer error_cnt = 0;
	integer n_tests = 0;
	// ========
	initial
	begin
		forever #25 clk = ~clk;
	end
	adcsp_port u_adcsp_port (.clk(clk), .reset(reset), .mode_sel(mode_sel),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .register_select(sel),
		.sclk_in(sck_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdata_in(sd_w),
		.sdata_out(sdata_out), .sdata_oe(sdata_oe), .result_ready_n(rrdy_n),
		.result_data(res_d), .result_valid(res_v), .result_ready(res_rdy),
		.ctrl_word(ctrl_word), .cal_word(cal_word));
	adcsp_host u_adcsp_host (.clk(clk), .sck_w(sck_w), .sclk_oe(sclk_oe), .sdo(sd_w),
		.mode_sel(mode_sel), .rd_n(rd_n), .wr_n(wr_n), .sel(sel), .sck(h_sck), .sdi(sdi));
	// ========
	task chk_w(input [63:0] nm, input [23:0] e, input [23:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e)
			begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task chk_b(input [63:0] nm, input e, input g);
		chk_w(nm, {23'h000000, e}, {23'h000000, g});
	endtask
	// expired host waits count as mismatches
	task test_done;
		begin
			error_cnt = error_cnt + u_adcsp_host.hang;
			$display("tests %0d errors %0d", n_tests, error_cnt);
			if (error_cnt == 0 && n_tests > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// ========
	// external write to control, self-clocked read back
	task t_ctrl;
		begin
			u_adcsp_host.xfer(0, 0, 0, 24'ha5c3f1, 24, 0, r);
			chk_w("ctrl", 24'ha5c3f1, ctrl_word);
			u_adcsp_host.xfer(1, 1, 0, 24'h000000, 24, 0, r);
			chk_w("rd_ctrl", 24'ha5c3f1, r);
			chk_b("oe_end", 0, u_adcsp_host.oe_end);
		end
	endtask
	// paused write to calibration, then a self write cut short
	task t_cal;
		begin
			u_adcsp_host.xfer(0, 0, 1, 24'h3c96e1, 24, 1, r);
			chk_w("cal", 24'h3c96e1, cal_word);
			chk_w("ctrl", 24'ha5c3f1, ctrl_word);
			u_adcsp_host.xfer(0, 1, 1, 24'h0f0f0f, 10, 0, r);
			chk_b("oe_mid", 1, u_adcsp_host.oe_end);
			chk_b("oe_rel", 0, sclk_oe);
			chk_w("cal", 24'h3c96e1, cal_word);
		end
	endtask
	// fill the buffer until refused, drain it through paused reads
	task t_fifo;
		begin
			k = 5'h00;
			@(posedge clk);
			res_v <= 1;
			res_d <= 24'h5a0000;
			@(negedge clk);
			while (k < 20 && res_rdy)
			begin
				@(posedge clk);
				k = k + 5'h01;
				res_d <= 24'h5a0000 + {19'h00000, k};
				@(negedge clk);
			end
			@(posedge clk);
			res_v <= 0;
			chk_w("fill", 24'h000010, {19'h00000, k});
			chk_b("rdy_n", 0, rrdy_n);
			for (k = 5'h00; k < 16; k = k + 5'h01)
			begin
				u_adcsp_host.xfer(1, 0, 1, 24'h000000, 24, 1, r);
				chk_w("data", 24'h5a0000 + {19'h00000, k}, r);
			end
			chk_b("empty_n", 1, rrdy_n);
		end
	endtask
	// ========
	initial
	begin
		repeat (100000) @(posedge clk);
		error_cnt = error_cnt + 1;
		test_done;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 0;
		repeat (4) @(posedge clk);
		t_ctrl;
		t_cal;
		t_fifo;
		test_done;
	end
endmodule // adc_serial_port_clock_select_bench
